// ### hdl/aea_energy_acc.sv
// Contract
// - skip samples below no-load threshold
// - set no-load flag while below threshold
// - enabled flag holds interrupt until cleared
// - two-bit code selects threshold, 00 off
// - 49-bit signed accumulator, upper 24 readable
// - one sample added every five clocks
// - both mode bits clear: signed accumulation
// - both mode bits set: positive-only wins
// - positive-only mode drops every negative sample
// - absolute mode adds magnitude, keeps no-load
// - sign and no-load detection active in every accumulation mode
// - 8-bit divisor, zero divides by one
// - read-clear returns energy, zeroes upper bits
// - energy wraps around at full scale
// - half-full and wrap raise enabled interrupts
// - active power samples at selectable rates
// - active-low pulse output follows mode
// - line mode aligns to zero crossings
// - line mode counts programmed half cycles
// - cycle end flags and restarts accumulation
// - count write clears, restarts at crossing
// - half cycle count is 16 bits
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module aea_energy_acc #(
  parameter int unsigned                    WAVE_PERIOD  = aea_pkg::WAVE_PERIOD_CYCLES,
  parameter logic [aea_pkg::PWR_W-1:0]      FULL_SCALE   = aea_pkg::FULL_SCALE_DEF,
  parameter logic [aea_pkg::CF_W-1:0]       CF_THRESHOLD = aea_pkg::CF_THRESHOLD_DEF,
  parameter int unsigned                    CF_PULSE     = aea_pkg::CF_PULSE_CYCLES
) (
  // clock and reset
  input  wire logic                         I_CORE_CLK,
  input  wire logic                         I_RST_N,
  // register port
  input  wire aea_pkg::aea_reg_req_t        I_REG_REQ,
  output logic [aea_pkg::DAT_W-1:0]         O_REG_RDATA,
  // power samples and voltage zero crossing
  input  wire logic signed [aea_pkg::PWR_W-1:0] I_POWER,
  input  wire logic                         I_ZERO_CROSS,
  // outputs to the core and the outside
  output logic                              O_MEASURE_IRQ,
  output logic                              O_ENERGY_PULSE_N,
  output aea_pkg::aea_wave_t                O_WAVE
);
  import aea_pkg::*;

  if (WAVE_PERIOD < 1 || WAVE_PERIOD > 131071 || CF_THRESHOLD == '0 ||
      CF_PULSE < 1 || CF_PULSE > 65535) begin : g_chk
    $error("aea_energy_acc: parameter out of range");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic wr_at(input logic [7:0] ofs);
    return I_REG_REQ.wr && (I_REG_REQ.addr == ofs);
  endfunction

  function automatic logic rd_at(input logic [7:0] ofs);
    return I_REG_REQ.rd && (I_REG_REQ.addr == ofs);
  endfunction

  // scaled full scale, widened so the product cannot overflow
  function automatic logic [PWR_W-1:0] nl_threshold(input logic [1:0] code);
    logic [63:0] ppb;
    ppb = 64'h0;
    unique case (code)
      2'h0: ppb = 64'h0;
      2'h1: ppb = 64'(NL_THR_PPB_1);
      2'h2: ppb = 64'(NL_THR_PPB_2);
      2'h3: ppb = 64'(NL_THR_PPB_3);
    endcase
    return PWR_W'((64'(FULL_SCALE) * ppb) / 64'd1_000_000_000);
  endfunction

  // divide magnitude so rounding is symmetric around zero
  function automatic logic signed [GW-1:0] div_sample(input logic signed [GW-1:0] x,
                                                      input logic [7:0] d);
    logic [GW-1:0] mag;
    logic [GW-1:0] q;
    mag = x[GW-1] ? GW'(-x) : GW'(x);
    q   = mag / GW'((d == 8'h00) ? 8'h01 : d);
    return x[GW-1] ? -$signed(q) : $signed(q);
  endfunction

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0]  wave_src_reg, nl_cfg_reg, acc_cfg_reg, en_lo_reg, en_hi_reg;
  logic [7:0]  divisor_reg;
  logic [11:0] gain_reg;
  logic [15:0] half_cyc_reg;

  // plain stores; all modes come up as signed accumulation
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      wave_src_reg <= REG_RESET;
      nl_cfg_reg   <= REG_RESET;
      acc_cfg_reg  <= REG_RESET;
      en_lo_reg    <= REG_RESET;
      en_hi_reg    <= REG_RESET;
      divisor_reg  <= REG_RESET;
      gain_reg     <= 12'h000;
      half_cyc_reg <= 16'h0000;
    end else begin
      if (wr_at(OFS_WAVE_SRC))  wave_src_reg <= I_REG_REQ.wdata[7:0];
      if (wr_at(OFS_NL_CFG))    nl_cfg_reg   <= I_REG_REQ.wdata[7:0];
      if (wr_at(OFS_ACC_CFG))   acc_cfg_reg  <= I_REG_REQ.wdata[7:0];
      if (wr_at(OFS_IRQ_EN_LO)) en_lo_reg    <= I_REG_REQ.wdata[7:0];
      if (wr_at(OFS_IRQ_EN_HI)) en_hi_reg    <= I_REG_REQ.wdata[7:0];
      if (wr_at(OFS_DIVISOR))   divisor_reg  <= I_REG_REQ.wdata[7:0];
      if (wr_at(OFS_GAIN))      gain_reg     <= I_REG_REQ.wdata[11:0];
      if (wr_at(OFS_HALF_CYC))  half_cyc_reg <= I_REG_REQ.wdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // accumulation tick
  // ---------------------------------------------------------------
  logic [2:0] tick_cnt_reg;
  wire        tick = (tick_cnt_reg == 3'(ACC_TICK_CYCLES - 1));

  // free-running divide by five
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N || tick) tick_cnt_reg <= 3'h0;
    else                  tick_cnt_reg <= tick_cnt_reg + 3'h1;
  end

  // ---------------------------------------------------------------
  // sample path: gain, no-load, mode, divisor
  // ---------------------------------------------------------------
  wire signed [PWR_W+11:0] gprod   = I_POWER * $signed(gain_reg);
  wire signed [GW-1:0]     gained  = GW'(I_POWER) + GW'(gprod >>> 12);
  wire [PWR_W-1:0]         raw_mag = I_POWER[PWR_W-1] ? PWR_W'(-I_POWER) : PWR_W'(I_POWER);
  wire [PWR_W-1:0]         nl_thr  = nl_threshold(nl_cfg_reg[1:0]);
  // creep guard compares the raw multiplier output, not the gained one
  wire below    = (nl_cfg_reg[1:0] != 2'h0) && (raw_mag < nl_thr);
  wire pos_mode = acc_cfg_reg[ACC_POS_ONLY_BIT];
  wire abs_mode = acc_cfg_reg[ACC_ABS_BIT] && !pos_mode;

  // shared by energy and pulse paths so both follow the same mode
  function automatic logic signed [GW-1:0] mode_filter(input logic signed [GW-1:0] x);
    if (below)                      return '0;
    else if (pos_mode && x[GW-1])   return '0;
    else if (abs_mode && x[GW-1])   return -x;
    else                            return x;
  endfunction

  wire signed [GW-1:0] quot       = div_sample(gained, divisor_reg);
  wire signed [GW-1:0] contrib    = mode_filter(quot);
  wire signed [GW-1:0] cf_contrib = mode_filter(gained);

  // ---------------------------------------------------------------
  // energy accumulator
  // ---------------------------------------------------------------
  logic signed [ACC_W-1:0] acc_reg;
  wire rc_read = rd_at(OFS_ENERGY_RC);
  wire signed [ACC_W-1:0] acc_sum   = acc_reg + ACC_W'(contrib);
  wire signed [ACC_W-1:0] acc_added = tick ? acc_sum : acc_reg;
  // read-clear drops only the visible bits; the fraction below survives
  wire signed [ACC_W-1:0] acc_next  = rc_read ?
    {{E_W{1'b0}}, acc_added[ACC_W-E_W-1:0]} : acc_added;
  wire [E_W-1:0] energy = acc_reg[ACC_W-1 -: E_W];
  wire [1:0]     e_top  = acc_reg[ACC_W-1 -: 2];
  wire [1:0]     n_top  = acc_added[ACC_W-1 -: 2];
  wire half_ev = tick && ((e_top == 2'h0 && n_top == 2'h1) ||
                          (e_top == 2'h3 && n_top == 2'h2));
  wire wrap_ev = tick && ((e_top == 2'h1 && n_top == 2'h2) ||
                          (e_top == 2'h2 && n_top == 2'h1));

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) acc_reg <= '0;
    else          acc_reg <= acc_next;
  end

  // ---------------------------------------------------------------
  // direction change detection
  // ---------------------------------------------------------------
  logic sign_prev_reg;
  wire  neg_now = gained[GW-1];
  wire  sign_ev = tick && (acc_cfg_reg[ACC_SIGN_DIR_BIT] ?
                  (sign_prev_reg && !neg_now) : (!sign_prev_reg && neg_now));

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N)  sign_prev_reg <= 1'b0;
    else if (tick) sign_prev_reg <= neg_now;
  end

  // ---------------------------------------------------------------
  // line cycle accumulation
  // ---------------------------------------------------------------
  aea_lc_state_t           lc_state_reg;
  logic [15:0]             lc_count_reg;
  logic signed [ACC_W-1:0] lacc_reg;
  logic [E_W-1:0]          line_energy_reg;
  wire line_mode = acc_cfg_reg[ACC_LINE_MODE_BIT];
  wire cnt_write = wr_at(OFS_HALF_CYC);
  wire signed [ACC_W-1:0] lacc_add = tick ? lacc_reg + ACC_W'(contrib) : lacc_reg;
  // a count of zero ends at the first crossing rather than never
  wire lc_last = (lc_state_reg == LC_RUN) && I_ZERO_CROSS &&
                 ({1'b0, lc_count_reg} + 17'h1 >= {1'b0, half_cyc_reg});
  wire cyc_end_ev = lc_last && line_mode && !cnt_write;

  // wait for a crossing, then count half cycles until the limit
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      lc_state_reg    <= LC_WAIT;
      lc_count_reg    <= 16'h0000;
      lacc_reg        <= '0;
      line_energy_reg <= '0;
    end else if (cnt_write || !line_mode) begin
      lc_state_reg <= LC_WAIT;
      lc_count_reg <= 16'h0000;
      lacc_reg     <= '0;
      if (cnt_write) line_energy_reg <= '0;
    end else begin
      unique case (lc_state_reg)
        LC_WAIT: if (I_ZERO_CROSS) begin
          lc_state_reg <= LC_RUN;
          lc_count_reg <= 16'h0000;
          lacc_reg     <= '0;
        end
        LC_RUN: if (lc_last) begin
          // unread result is simply overwritten by the next one
          line_energy_reg <= lacc_add[ACC_W-1 -: E_W];
          lacc_reg        <= '0;
          lc_count_reg    <= 16'h0000;
        end else begin
          lacc_reg <= lacc_add;
          if (I_ZERO_CROSS) lc_count_reg <= lc_count_reg + 16'h1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status flags and interrupt
  // ---------------------------------------------------------------
  logic [7:0] st_lo_reg, st_hi_reg;
  wire [7:0] st_lo_set = (8'(below)   << ST_NO_LOAD_BIT) |
                         (8'(sign_ev) << ST_SIGN_BIT) |
                         (8'(half_ev) << ST_HALF_BIT) |
                         (8'(wrap_ev) << ST_WRAP_BIT);
  wire [7:0] st_hi_set = 8'(cyc_end_ev) << ST_CYC_END_BIT;
  wire [7:0] st_lo_clr = wr_at(OFS_IRQ_ST_LO) ? I_REG_REQ.wdata[7:0] : 8'h00;
  wire [7:0] st_hi_clr = wr_at(OFS_IRQ_ST_HI) ? I_REG_REQ.wdata[7:0] : 8'h00;
  // named so the hold check sees a sampled value, not a live call
  wire       en_lo_wr  = wr_at(OFS_IRQ_EN_LO);

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      st_lo_reg <= REG_RESET;
      st_hi_reg <= REG_RESET;
    end else begin
      st_lo_reg <= (st_lo_reg & ~st_lo_clr) | st_lo_set;
      st_hi_reg <= (st_hi_reg & ~st_hi_clr) | st_hi_set;
    end
  end

  // level interrupt, falls only when software clears the flag or its enable
  assign O_MEASURE_IRQ = (|(st_lo_reg & en_lo_reg)) ||
                         (|(st_hi_reg & en_hi_reg & (8'h01 << ST_CYC_END_BIT)));

  // ---------------------------------------------------------------
  // pulse output
  // ---------------------------------------------------------------
  logic signed [CF_W-1:0] cf_acc_reg;
  logic [15:0]            cf_cnt_reg;
  logic                   cf_pulse_n_reg;
  wire signed [CF_W-1:0] cf_thr  = $signed(CF_THRESHOLD);
  wire signed [CF_W-1:0] cf_sum  = tick ? cf_acc_reg + CF_W'(cf_contrib) : cf_acc_reg;
  wire cf_pos  = cf_sum >= cf_thr;
  wire cf_neg  = cf_sum <= -cf_thr;
  // reverse flow also pulses in signed mode, as a meter LED would
  wire cf_fire = cf_pos || cf_neg;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      cf_acc_reg     <= '0;
      cf_cnt_reg     <= 16'h0000;
      cf_pulse_n_reg <= 1'b1;
    end else begin
      cf_acc_reg     <= cf_pos ? cf_sum - cf_thr : (cf_neg ? cf_sum + cf_thr : cf_sum);
      cf_cnt_reg     <= cf_fire ? 16'(CF_PULSE) :
                        ((cf_cnt_reg != 16'h0000) ? cf_cnt_reg - 16'h1 : 16'h0000);
      cf_pulse_n_reg <= !(cf_fire || cf_cnt_reg > 16'h0001);
    end
  end
  assign O_ENERGY_PULSE_N = cf_pulse_n_reg;

  // ---------------------------------------------------------------
  // waveform samples
  // ---------------------------------------------------------------
  logic [19:0] wave_cnt_reg;
  logic        wave_valid_reg;
  logic signed [GW-1:0] wave_sample_reg;
  wire        wave_on    = en_hi_reg[EN_WAVEFORM_SAMPLING_ENABLE_BIT] && (wave_src_reg[1:0] == WAVE_SRC_ACTIVE);
  wire [19:0] wave_limit = 20'(WAVE_PERIOD) << wave_src_reg[3:2];
  wire        wave_hit   = (wave_cnt_reg == wave_limit - 20'h1);

  // rate code halves the rate per step from the base rate
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      wave_cnt_reg    <= 20'h0;
      wave_valid_reg  <= 1'b0;
      wave_sample_reg <= '0;
    end else begin
      wave_cnt_reg   <= (!wave_on || wave_hit) ? 20'h0 : wave_cnt_reg + 20'h1;
      wave_valid_reg <= wave_on && wave_hit;
      if (wave_on && wave_hit) wave_sample_reg <= gained;
    end
  end
  assign O_WAVE = '{valid: wave_valid_reg, sample: wave_sample_reg};

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  logic [DAT_W-1:0] rdata_reg;
  wire  [7:0]       ra = I_REG_REQ.addr;
  wire  [DAT_W-1:0] rd_value =
    (ra == OFS_WAVE_SRC)    ? DAT_W'(wave_src_reg) :
    (ra == OFS_NL_CFG)      ? DAT_W'(nl_cfg_reg) :
    (ra == OFS_ACC_CFG)     ? DAT_W'(acc_cfg_reg) :
    (ra == OFS_ENERGY || ra == OFS_ENERGY_RC) ? energy :
    (ra == OFS_DIVISOR)     ? DAT_W'(divisor_reg) :
    (ra == OFS_LINE_ENERGY) ? line_energy_reg :
    (ra == OFS_HALF_CYC)    ? DAT_W'(half_cyc_reg) :
    (ra == OFS_GAIN)        ? DAT_W'(gain_reg) :
    (ra == OFS_IRQ_EN_LO)   ? DAT_W'(en_lo_reg) :
    (ra == OFS_IRQ_EN_HI)   ? DAT_W'(en_hi_reg) :
    (ra == OFS_IRQ_ST_LO)   ? DAT_W'(st_lo_reg) :
    (ra == OFS_IRQ_ST_HI)   ? DAT_W'(st_hi_reg) : '0;

  // data stands only in the cycle after the strobe
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) rdata_reg <= '0;
    else          rdata_reg <= I_REG_REQ.rd ? rd_value : '0;
  end
  assign O_REG_RDATA = rdata_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  a_tick_period: assert property (tick |=> !tick [*4] ##1 tick)
    else $error("tick spacing not five cycles");
  a_no_load_hold: assert property (tick && below && !rc_read |=> acc_reg == $past(acc_reg))
    else $error("sample below threshold accumulated");
  a_no_load_flag: assert property (below |=> st_lo_reg[ST_NO_LOAD_BIT])
    else $error("no-load flag not set");
  a_irq_flag_hold: assert property (st_lo_reg[ST_NO_LOAD_BIT] && en_lo_reg[ST_NO_LOAD_BIT]
      && !st_lo_clr[ST_NO_LOAD_BIT] && !en_lo_wr |=> O_MEASURE_IRQ)
    else $error("interrupt dropped without clear");
  a_nl_disabled: assert property (nl_cfg_reg[1:0] == 2'h0 && !st_lo_reg[ST_NO_LOAD_BIT]
      |-> !below ##1 !st_lo_reg[ST_NO_LOAD_BIT])
    else $error("no-load active while disabled");
  a_signed_add: assert property (tick && !pos_mode && !abs_mode && !below && !rc_read
      |=> acc_reg == $past(acc_reg) + ACC_W'($past(quot)))
    else $error("signed accumulation wrong");
  a_pos_only_drop: assert property (tick && acc_cfg_reg[ACC_POS_ONLY_BIT] && quot[GW-1]
      && !rc_read |=> acc_reg == $past(acc_reg))
    else $error("negative sample in positive-only mode");
  a_abs_nonneg: assert property (tick && abs_mode && !rc_read
      |=> $signed(acc_reg - $past(acc_reg)) >= 0)
    else $error("absolute mode decreased energy");
  a_div_unity: assert property (divisor_reg <= 8'h01 |-> quot == gained)
    else $error("divisor zero or one not unity");
  a_read_clear: assert property (rc_read |=> O_REG_RDATA == $past(energy) && energy == '0)
    else $error("read-clear failed");
  a_wrap_pos: assert property (tick && e_top == 2'h1 && n_top == 2'h2 && !rc_read
      |=> energy[E_W-1] && st_lo_reg[ST_WRAP_BIT])
    else $error("positive wrap wrong");
  a_cycle_end: assert property (cyc_end_ev |=> st_hi_reg[ST_CYC_END_BIT] && lc_count_reg == 16'h0
      && lc_state_reg == LC_RUN)
    else $error("cycle end not flagged or restarted");
  a_count_write: assert property (cnt_write |=> lc_state_reg == LC_WAIT && line_energy_reg == '0)
    else $error("count write did not restart");

  c_wrap:      cover property (wrap_ev);
  c_cycle_end: cover property (cyc_end_ev);
  c_pulse:     cover property ($fell(O_ENERGY_PULSE_N));
  c_wave:      cover property (O_WAVE.valid);
endmodule // aea_energy_acc

// ### hdl/aea_pkg.sv
package aea_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PWR_W = 24;           // multiplier output sample
  localparam int GW    = PWR_W + 1;    // gain-calibrated sample
  localparam int ACC_W = 49;           // internal energy accumulator
  localparam int E_W   = 24;           // readable energy window
  localparam int CF_W  = 32;           // pulse output accumulator
  localparam int DAT_W = 24;           // register port data

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_WAVE_SRC    = 8'h0D;
  localparam logic [7:0] OFS_NL_CFG      = 8'h0E;
  localparam logic [7:0] OFS_ACC_CFG     = 8'h0F;
  localparam logic [7:0] OFS_ENERGY      = 8'h10;
  localparam logic [7:0] OFS_ENERGY_RC   = 8'h11;
  localparam logic [7:0] OFS_DIVISOR     = 8'h12;
  localparam logic [7:0] OFS_LINE_ENERGY = 8'h13;
  localparam logic [7:0] OFS_HALF_CYC    = 8'h14;
  localparam logic [7:0] OFS_GAIN        = 8'h15;
  localparam logic [7:0] OFS_IRQ_EN_LO   = 8'hD9;
  localparam logic [7:0] OFS_IRQ_EN_HI   = 8'hDB;
  localparam logic [7:0] OFS_IRQ_ST_LO   = 8'hDC;
  localparam logic [7:0] OFS_IRQ_ST_HI   = 8'hDE;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ACC_POS_ONLY_BIT  = 0;
  localparam int ACC_ABS_BIT       = 1;
  localparam int ACC_SIGN_DIR_BIT  = 2;
  localparam int ACC_LINE_MODE_BIT = 3;
  localparam int ST_NO_LOAD_BIT    = 0;
  localparam int ST_SIGN_BIT       = 1;
  localparam int ST_HALF_BIT       = 2;
  localparam int ST_WRAP_BIT       = 3;
  localparam int ST_CYC_END_BIT    = 0;
  localparam int EN_WAVEFORM_SAMPLING_ENABLE_BIT       = 1;
  localparam logic [1:0] WAVE_SRC_ACTIVE = 2'h0;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ---------------------------------------------------------------
  // timing and thresholds
  // ---------------------------------------------------------------
  localparam longint CLK_HZ          = 125_000_000;
  localparam int     ACC_TICK_CYCLES = 5;
  localparam longint WAVE_RATE_HZ    = 25_600;
  localparam int     WAVE_PERIOD_CYCLES = int'(CLK_HZ / WAVE_RATE_HZ);
  localparam longint CF_PULSE_NS     = 1_000;
  localparam int     CF_PULSE_CYCLES =
    int'((CF_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam longint NL_THR_PPB_1    = 150_000;  // 0.015 %
  localparam longint NL_THR_PPB_2    = 75_000;   // 0.0075 %
  localparam longint NL_THR_PPB_3    = 37_000;   // 0.0037 %
  localparam logic [PWR_W-1:0] FULL_SCALE_DEF   = 24'h0CCCCD;
  localparam logic [CF_W-1:0]  CF_THRESHOLD_DEF = 32'h0100_0000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       addr;
    logic [DAT_W-1:0] wdata;
    logic             wr;
    logic             rd;
  } aea_reg_req_t;

  typedef struct packed {
    logic                 valid;
    logic signed [GW-1:0] sample;
  } aea_wave_t;

  typedef enum logic {LC_WAIT, LC_RUN} aea_lc_state_t;
endpackage

// ### test/active_energy_accumulator_bench.sv
`timescale 1ns/1ps
module active_energy_accumulator_bench;
  import aea_pkg::*;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  aea_reg_req_t       req = '0;
  logic signed [23:0] pwr = '0;
  logic signed [23:0] power;
  logic               zc;
  logic               irq;
  logic [23:0]        rdata;
  logic [23:0]        d;
  logic               pls_n;
  aea_wave_t          wv;
  int                 n_errors = 0;
  int                 checked = 0;
  initial forever #4 clk = ~clk;
  aea_pwr_src i_aea_pwr_src (.i_clk(clk), .i_level(pwr), .o_power(power), .o_zc(zc));
  // short wave and pulse counts keep the run brief
  aea_energy_acc #(.WAVE_PERIOD(8), .CF_THRESHOLD(32'h100), .CF_PULSE(4)) i_aea_energy_acc (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_REQ(req), .O_REG_RDATA(rdata),
    .I_POWER(power), .I_ZERO_CROSS(zc), .O_MEASURE_IRQ(irq),
    .O_ENERGY_PULSE_N(pls_n), .O_WAVE(wv));
  // ---------------------------------
  // register access
  // ---------------------------------
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // 80 cycles give exactly 16 ticks whatever the tick phase
  task automatic run(input logic [7:0] m, input logic [7:0] dv,
                     input logic signed [23:0] p, input logic [23:0] e);
    wr(OFS_ACC_CFG, {16'h0, m});
    wr(OFS_DIVISOR, {16'h0, dv});
    rd(OFS_ENERGY_RC);
    pwr <= p;
    repeat (80) @(posedge clk);
    pwr <= '0;
    repeat (4) @(posedge clk);
    rd(OFS_ENERGY);
    chk(d, e);
    rd(OFS_ENERGY_RC);
    chk(d, e);
    rd(OFS_ENERGY);
    chk(d, 24'h0);
    $display("test done mode %h divisor %h", m, dv);
  endtask
  // 80 cycles hold whole pulse (10) and wave (16) periods, so counts are exact
  task automatic pulse_wave(input logic [7:0] m, input logic signed [23:0] p,
                            input logic [23:0] e_low, input logic [23:0] e_smp);
    int n_low;
    int n_val;
    n_low = 0;
    n_val = 0;
    wr(OFS_ACC_CFG, {16'h0, m});
    pwr <= p;
    repeat (30) @(posedge clk);
    repeat (80) begin
      @(posedge clk);
      if (pls_n === 1'b0) n_low++;
      if (wv.valid === 1'b1) begin
        n_val++;
        chk(wv.sample[23:0], e_smp);
      end
    end
    pwr <= '0;
    chk(24'(n_low), e_low);
    chk(24'(n_val), 24'h5);
    $display("test done pulse and wave mode %h", m);
  endtask
  // ---------------------------------
  // tests
  // ---------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_ACC_CFG);
    chk(d, 24'h0);
    wr(8'h40, 24'h5A);
    rd(8'h40);
    chk(d, 24'h0);
    $display("test done reset");
    wr(OFS_WAVE_SRC, 24'h4);
    wr(OFS_IRQ_EN_HI, 24'h2);
    pulse_wave(8'h0, 24'sh80, 24'h20, 24'h000080);
    pulse_wave(8'h1, -24'sh80, 24'h0, 24'hFFFF80);
    run(8'h0, 8'h0, 24'sh400000, 24'h000002);
    run(8'h0, 8'h0, -24'sh400000, 24'hFFFFFE);
    run(8'h1, 8'h0, -24'sh400000, 24'h000000);
    run(8'h2, 8'h0, -24'sh400000, 24'h000002);
    run(8'h3, 8'h0, -24'sh400000, 24'h000000);
    run(8'h0, 8'h2, 24'sh400000, 24'h000001);
    wr(OFS_IRQ_ST_LO, 24'h0F);
    wr(OFS_NL_CFG, 24'h1);
    wr(OFS_IRQ_EN_LO, 24'h1);
    pwr <= 24'sh10;
    repeat (10) @(posedge clk);
    rd(OFS_IRQ_ST_LO);
    chk(d & 24'h1, 24'h1);
    chk({23'h0, irq}, 24'h1);
    pwr <= 24'sh100000;
    repeat (10) @(posedge clk);
    chk({23'h0, irq}, 24'h1);
    wr(OFS_IRQ_ST_LO, 24'h1);
    rd(OFS_IRQ_ST_LO);
    chk(d & 24'h1, 24'h0);
    chk({23'h0, irq}, 24'h0);
    $display("test done no-load");
    pwr <= 24'sh400000;
    wr(OFS_ACC_CFG, 24'h8);
    wr(OFS_DIVISOR, 24'h0);
    wr(OFS_HALF_CYC, 24'h4);
    rd(OFS_LINE_ENERGY);
    chk(d, 24'h0);
    repeat (250) @(posedge clk);
    rd(OFS_LINE_ENERGY);
    chk(d, 24'h000004);
    rd(OFS_IRQ_ST_HI);
    chk(d & 24'h1, 24'h1);
    rd(OFS_HALF_CYC);
    chk(d, 24'h4);
    $display("test done line cycle");
    stop_test;
  end
  // hang guard, well past the expected length
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule // active_energy_accumulator_bench

// ### test/aea_pwr_src.sv
`timescale 1ns/1ps
// ---------------------------------
// power sample and line source
// ---------------------------------
module aea_pwr_src #(
  parameter int ZC_GAP = 40
) (
  // clock
  input  wire logic               i_clk,
  // level asked for by the bench
  input  wire logic signed [23:0] i_level,
  // toward the block
  output logic signed [23:0]      o_power = '0,
  output logic                    o_zc = 1'b0
);
  int cnt = 0;
  // one-cycle crossing pulse at a fixed spacing; power lags one cycle
  always @(posedge i_clk) begin
    o_power <= i_level;
    cnt     <= (cnt == ZC_GAP - 1) ? 0 : cnt + 1;
    o_zc    <= (cnt == 0);
  end
endmodule // aea_pwr_src
